// file: fpe_engine.sv
// Flash programming command engine behind the serial debug scan port.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpe_engine
  import fpe_pkg::*;
#(
  parameter int WORDS_PER_PAGE = 128,
  parameter int REGION_PAGES_LOG2 = 4,
  parameter int LOCK_W = 32,
  parameter int OPT_W = 8,
  parameter int ERASE_HOLD = int'(ERASE_HOLD_CYCLES),
  parameter logic [15:0] OP_WP = OPC_WP,
  parameter logic [15:0] OP_WPL = OPC_WPL,
  parameter logic [15:0] OP_EWP = OPC_EWP,
  parameter logic [15:0] OP_ERASE_WRITE_THEN_LOCK = OPC_ERASE_WRITE_THEN_LOCK,
  parameter logic [15:0] OP_EA = OPC_EA,
  parameter logic [15:0] OP_SLB = OPC_SLB,
  parameter logic [15:0] OP_CLB = OPC_CLB,
  parameter logic [15:0] OP_GLB = OPC_GLB,
  parameter logic [15:0] OP_SOPT = OPC_SOPT,
  parameter logic [15:0] OP_COPT = OPC_COPT,
  parameter logic [15:0] OP_GOPT = OPC_GOPT,
  parameter logic [15:0] OP_SSEC = OPC_SSEC,
  parameter logic [15:0] OP_MWR = OPC_MWR,
  parameter logic [15:0] OP_GVER = OPC_GVER,
  parameter logic [31:0] VERSION = IF_VERSION
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Test access port pins.
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  // Erase and test select pins.
  input wire logic erase_pin_i,
  input wire logic test_select_pin_i,
  // Flash macro.
  output logic flash_req_o,
  output fpe_fop_t flash_op_o,
  output logic [31:0] flash_page_o,
  input wire logic flash_done_i,
  input wire logic [$clog2(WORDS_PER_PAGE)-1:0] flash_word_idx_i,
  output logic [31:0] flash_word_o,
  // Memory write port.
  output logic mem_wr_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  // State seen by the rest of the chip.
  output logic secured_o,
  output logic [LOCK_W-1:0] lock_bits_o,
  output logic [OPT_W-1:0] user_option_bits_o
);
  localparam int WAW = $clog2(WORDS_PER_PAGE);
  localparam int PAGE_SHIFT = WAW + 2;
  localparam int HOLD_W = $clog2(ERASE_HOLD + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(ERASE_HOLD);

  //----------------------------------------------------------------------------
  // Pin synchronisation and clock edge detection
  //----------------------------------------------------------------------------
  logic tck_s, tms_s, tdi_s, erase_s, tsel_s, tck_q;
  fpe_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({tck_i, tms_i, tdi_i, erase_pin_i, test_select_pin_i}),
    .q_o({tck_s, tms_s, tdi_s, erase_s, tsel_s})
  );
  wire tck_rise = tck_s & ~tck_q;
  wire tck_fall = ~tck_s & tck_q;

  //----------------------------------------------------------------------------
  // Test access port controller
  //----------------------------------------------------------------------------
  typedef enum logic [15:0] {
    TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
    TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020, TS_PA_DR = 16'h0040, TS_EX2_DR = 16'h0080,
    TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
    TS_EX1_IR = 16'h1000, TS_PA_IR = 16'h2000, TS_EX2_IR = 16'h4000, TS_UPD_IR = 16'h8000
  } fpe_tap_t;
  fpe_tap_t tap, next_tap;

  always_comb
  begin
    unique case (tap)
      TS_RESET: next_tap = tms_s ? TS_RESET : TS_IDLE;
      TS_IDLE: next_tap = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: next_tap = tms_s ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: next_tap = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: next_tap = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: next_tap = tms_s ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: next_tap = tms_s ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: next_tap = tms_s ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: next_tap = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: next_tap = tms_s ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: next_tap = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: next_tap = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: next_tap = tms_s ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: next_tap = tms_s ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: next_tap = tms_s ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: next_tap = tms_s ? TS_SEL_DR : TS_IDLE;
      default: next_tap = TS_RESET;
    endcase
  end

  //----------------------------------------------------------------------------
  // Scan register and comms channel
  //----------------------------------------------------------------------------
  logic [SCAN_W-1:0] scan;
  logic [4:0] read_sel;
  logic [31:0] rx_word, tx_word;
  logic rx_pend, tx_avail, rx_take, tx_load;
  logic [31:0] tx_next;

  wire upd_now = tck_rise && tap == TS_UPD_DR;
  wire [4:0] scan_addr = scan[SCAN_ADDR_LSB +: SCAN_ADDR_W];
  wire scan_wr = scan[SCAN_RW_BIT];
  wire wr_data = upd_now && scan_wr && scan_addr == SCAN_ADDR_DATA;
  wire rd_data = upd_now && !scan_wr && scan_addr == SCAN_ADDR_DATA;
  wire [31:0] ctrl_word = {30'h0, tx_avail, rx_pend};
  wire [31:0] cap_word = read_sel == SCAN_ADDR_CTRL ? ctrl_word :
                         read_sel == SCAN_ADDR_DATA ? tx_word : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tck_q <= 1'b0;
      tap <= TS_RESET;
      scan <= '0;
      read_sel <= 5'h00;
      tdo_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tck_q <= tck_s;
      if (tck_rise)
        tap <= next_tap;
      if (tck_rise && tap == TS_CAP_DR)
        scan <= {1'b0, read_sel, cap_word};
      else if (tck_rise && tap == TS_SH_DR)
        scan <= {tdi_s, scan[SCAN_W-1:1]};
      if (upd_now && !scan_wr)
        read_sel <= scan_addr;
      if (tck_fall)
        tdo_o <= scan[0];
    end
  end

  // A word written while the previous one is unread is dropped; the pending
  // flag tells the programmer to wait, and a take beats a newly arrived word.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_pend <= 1'b0;
      rx_word <= 32'h0000_0000;
      tx_avail <= 1'b0;
      tx_word <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (wr_data && !rx_pend)
        rx_word <= scan[31:0];
      rx_pend <= (wr_data && !rx_pend) || (rx_pend && !rx_take);
      if (tx_load)
        tx_word <= tx_next;
      tx_avail <= tx_load || (tx_avail && !rd_data);
    end
  end

  //----------------------------------------------------------------------------
  // Command engine
  //----------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ES_IDLE = 7'h01, ES_ADDR = 7'h02, ES_DATA = 7'h04, ES_MASK = 7'h08,
    ES_FLUSH = 7'h10, ES_MEMWR = 7'h20, ES_REPLY = 7'h40
  } fpe_est_t;
  fpe_est_t est;
  logic [15:0] cmd, count;
  logic [31:0] addr, reply, buf_page;
  logic buf_valid, erase_pend, erase_all, secured, enable;
  logic [LOCK_W-1:0] locks;
  logic [OPT_W-1:0] opts;
  logic [HOLD_W-1:0] hold_cnt;

  wire [15:0] opc = rx_word[OPCODE_W-1:0];
  wire [15:0] hdr_count = rx_word[31:COUNT_LSB];
  wire op_page = opc == OP_WP || opc == OP_WPL || opc == OP_EWP || opc == OP_ERASE_WRITE_THEN_LOCK;
  wire op_mask = opc == OP_SLB || opc == OP_CLB || opc == OP_SOPT || opc == OP_COPT;
  wire cmd_mem = cmd == OP_MWR;
  wire cmd_erase = cmd == OP_EWP || cmd == OP_ERASE_WRITE_THEN_LOCK;
  wire cmd_lock = cmd == OP_WPL || cmd == OP_ERASE_WRITE_THEN_LOCK;
  wire [31:0] addr_page = addr >> PAGE_SHIFT;
  wire page_miss = buf_valid && addr_page != buf_page;
  wire [31:0] region = buf_page >> REGION_PAGES_LOG2;
  wire pin_fire = hold_cnt == HOLD_LAST - 1'b1 && erase_s && !tsel_s;
  wire data_take = est == ES_DATA && rx_pend && !cmd_mem && !page_miss;
  wire [31:0] next_addr = addr + ADDR_STEP;

  assign rx_take = rx_pend && enable && (est == ES_IDLE || est == ES_ADDR || est == ES_MASK
                   || data_take || (est == ES_DATA && cmd_mem));
  assign tx_load = est == ES_REPLY && !tx_avail;
  assign tx_next = reply;
  assign flash_req_o = est == ES_FLUSH;
  assign flash_op_o = erase_all ? FOP_ERASE_ALL : erase_pend ? FOP_ERASE_PAGE : FOP_PROGRAM;
  assign flash_page_o = buf_page;
  assign mem_wr_o = est == ES_MEMWR;
  assign secured_o = secured;
  assign lock_bits_o = locks;
  assign user_option_bits_o = opts;

  fpe_page_buf #(.DEPTH(WORDS_PER_PAGE), .AW(WAW)) u_buf (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(data_take),
    .waddr_i(addr[2 +: WAW]),
    .wdata_i(rx_word),
    .raddr_i(flash_word_idx_i),
    .rdata_o(flash_word_o)
  );

  // Erase pin hold timer; it only runs while test select is low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_cnt <= '0;
    else if (ce_i)
      hold_cnt <= (!erase_s || tsel_s) ? '0 : (hold_cnt == HOLD_LAST ? hold_cnt : hold_cnt + 1'b1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      est <= ES_IDLE;
      cmd <= 16'h0000;
      count <= 16'h0000;
      addr <= 32'h0000_0000;
      reply <= 32'h0000_0000;
      buf_page <= 32'h0000_0000;
      buf_valid <= 1'b0;
      erase_pend <= 1'b0;
      erase_all <= 1'b0;
      secured <= 1'b0;
      locks <= '0;
      opts <= '0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (pin_fire && !(est == ES_FLUSH && erase_all))
      begin
        // A held erase pin aborts whatever runs, except an erase-all already under way, and wipes the plane.
        erase_all <= 1'b1;
        buf_valid <= 1'b0;
        est <= ES_FLUSH;
      end
      else
      begin
        unique case (est)
          ES_IDLE:
          begin
            if (rx_take && !secured)
            begin
              cmd <= opc;
              count <= hdr_count;
              erase_pend <= opc == OP_EWP || opc == OP_ERASE_WRITE_THEN_LOCK;
              if (op_page || opc == OP_MWR)
                est <= ES_ADDR;
              else if (op_mask)
                est <= ES_MASK;
              else if (opc == OP_EA)
              begin
                erase_all <= 1'b1;
                est <= ES_FLUSH;
              end
              else if (opc == OP_GLB || opc == OP_GOPT || opc == OP_GVER)
              begin
                reply <= opc == OP_GLB ? 32'(locks) :
                         opc == OP_GOPT ? 32'(opts) : VERSION;
                est <= ES_REPLY;
              end
              else if (opc == OP_SSEC)
                secured <= 1'b1;
              // Any other opcode is dropped with no effect.
            end
          end
          ES_ADDR:
          begin
            if (rx_take)
            begin
              addr <= rx_word;
              est <= count == 16'h0000 ? ES_IDLE : ES_DATA;
            end
          end
          ES_DATA:
          begin
            if (rx_pend && cmd_mem)
            begin
              mem_addr_o <= addr;
              mem_wdata_o <= rx_word;
              est <= ES_MEMWR;
            end
            else if (rx_pend && page_miss)
              est <= ES_FLUSH;
            else if (data_take)
            begin
              buf_page <= addr_page;
              buf_valid <= 1'b1;
              addr <= next_addr;
              count <= count - 16'h0001;
              if (count == 16'h0001)
                est <= ES_FLUSH;
            end
          end
          ES_MASK:
          begin
            if (rx_take)
            begin
              if (cmd == OP_SLB)
                locks <= locks | rx_word[LOCK_W-1:0];
              else if (cmd == OP_CLB)
                locks <= locks & ~rx_word[LOCK_W-1:0];
              else if (cmd == OP_SOPT)
                opts <= opts | rx_word[OPT_W-1:0];
              else
                opts <= opts & ~rx_word[OPT_W-1:0];
              est <= ES_IDLE;
            end
          end
          ES_FLUSH:
          begin
            if (flash_done_i && erase_all)
            begin
              erase_all <= 1'b0;
              locks <= '0;
              opts <= '0;
              secured <= 1'b0;
              est <= ES_IDLE;
            end
            else if (flash_done_i && erase_pend)
              erase_pend <= 1'b0;
            else if (flash_done_i)
            begin
              if (cmd_lock)
                locks <= locks | (LOCK_W'(1) << region[$clog2(LOCK_W)-1:0]);
              buf_valid <= 1'b0;
              erase_pend <= cmd_erase;
              est <= count == 16'h0000 ? ES_IDLE : ES_DATA;
            end
          end
          ES_MEMWR:
          begin
            if (mem_ack_i)
            begin
              addr <= next_addr;
              count <= count - 16'h0001;
              est <= count == 16'h0001 ? ES_IDLE : ES_DATA;
            end
          end
          ES_REPLY:
          begin
            if (tx_load)
              est <= ES_IDLE;
          end
          default: est <= ES_IDLE;
        endcase
      end
    end
  end

  //----------------------------------------------------------------------------
  // Wishbone registers
  //----------------------------------------------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [31:0] stat_word = {28'h0, tx_avail, rx_pend, secured, est != ES_IDLE};
  wire [31:0] rd_word = wb_adr_i == REG_CTRL ? {31'h0, enable} :
                        wb_adr_i == REG_STATUS ? stat_word :
                        wb_adr_i == REG_LOCK ? 32'(locks) :
                        wb_adr_i == REG_OPTION ? 32'(opts) : 32'h0000_0000;

  // Clearing enable freezes command intake except in ES_DATA, which keeps reusing the pending word; flash work finishes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      enable <= CTRL_EN_RESET;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_word;
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL)
        enable <= wb_dat_i[CTRL_EN_BIT];
    end
  end
endmodule // fpe_engine
`default_nettype wire

// file: fpe_engine_bench.sv
// Self-checking bench for the flash programming command engine.
`timescale 1ns/1ps
`default_nettype none
module fpe_engine_bench
  import fpe_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wreq = 1'b0, wwe = 1'b0, fdone = 1'b0, mack = 1'b0, erase = 1'b0, tsel = 1'b1, ce = 1'b1;
  logic [7:0] wadr = 8'h00, opt;
  logic [31:0] wdat = 32'h0, wbq, fpage, fword, maddr, mdata, q, lock;
  logic ack, tck, tms, tdi, tdo, freq, mwr, sec, hang;
  logic [2:0] fcnt = 3'h0;
  logic [3:0] wsel = 4'hF;
  fpe_fop_t fop;
  logic [41:0] flog[$];
  logic [63:0] mlog[$];
  int fail_count = 0;
  int tests_run = 0;
  always #25 clk_i = ~clk_i;
  fpe_engine #(.ERASE_HOLD(20)) u_dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(wreq),
    .wb_stb_i(wreq), .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(wsel), .wb_dat_i(wdat),
    .wb_dat_o(wbq), .wb_ack_o(ack), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .erase_pin_i(erase), .test_select_pin_i(tsel), .flash_req_o(freq), .flash_op_o(fop),
    .flash_page_o(fpage), .flash_done_i(fdone), .flash_word_idx_i(fpage[0] ? 7'h7F : 7'h00),
    .flash_word_o(fword), .mem_wr_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mdata),
    .mem_ack_i(mack), .secured_o(sec), .lock_bits_o(lock), .user_option_bits_o(opt));
  fpe_prog_model u_prog (.clk_i, .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .hang_o(hang));
  always @(posedge hang)
  begin
    chk("poll_hang", 64'h0, 64'h1);
    end_sim();
  end
  // Flash macro answers after four cycles; the word logged is the last one of odd pages.
  always @(posedge clk_i)
  begin
    fdone <= freq && !fdone && fcnt == 3'h3;
    fcnt <= (freq && !fdone) ? fcnt + 3'h1 : 3'h0;
    if (freq && !fdone && fcnt == 3'h3)
      flog.push_back({fop, fpage[7:0], (fop == FOP_PROGRAM) ? fword : 32'h0});
    mack <= mwr && !mack;
    if (mwr && !mack)
      mlog.push_back({maddr, mdata});
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wreq <= 1'b1;
    wwe <= we;
    wadr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && ++n < 50);
    q = wbq;
    wreq <= 1'b0;
    if (n >= 50)
    begin
      chk("bus_wait", 64'h0, 64'h1);
      end_sim();
    end
  endtask
  task automatic wlog(input int n);
    for (int k = 0; k < 200; k++)
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      if (flog.size() >= n && q[STAT_BUSY_BIT] === 1'b0) return;
    end
    chk("flash_wait", 64'h0, 64'h1);
    end_sim();
  endtask
  task automatic cmd(input logic [31:0] op, input logic [31:0] w);
    u_prog.put(op);
    u_prog.put(w);
  endtask
  task automatic pw(input logic [31:0] op, input logic [31:0] a, input logic [31:0] w);
    flog.delete();
    cmd(op, a);
    u_prog.put(w);
    wlog(2);
    chk("erase_first", {FOP_ERASE_PAGE, a[16:9], 32'h0}, flog[0]);
    chk("then_program", {FOP_PROGRAM, a[16:9], w}, flog[1]);
  endtask
  task automatic t_regs();
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 64'h1, q);
    wsel <= 4'hE;
    wb(1'b1, REG_CTRL, 32'h0);
    wsel <= 4'hF;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_sel", 64'h1, q);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 64'h0, q);
    wb(1'b1, REG_CTRL, 32'h0);
    u_prog.put({16'h0000, OPC_GVER});
    wb(1'b0, REG_STATUS, 32'h0);
    chk("held_word", 64'h4, q);
    wb(1'b1, REG_CTRL, 32'h1);
    u_prog.get(q);
    chk("version", IF_VERSION, q);
    $display("t_regs done");
  endtask
  task automatic t_masks();
    cmd(OPC_SLB, 32'h0000_0005);
    cmd(OPC_CLB, 32'h0000_0001);
    u_prog.put({16'h0000, OPC_GLB});
    u_prog.get(q);
    chk("lock_mask", 64'h4, q);
    cmd(OPC_SOPT, 32'h0000_0083);
    cmd(OPC_COPT, 32'h0000_0002);
    u_prog.put({16'h0000, OPC_GOPT});
    u_prog.get(q);
    chk("opt_mask", 64'h81, q);
    u_prog.put(32'h0000_00FF);
    wb(1'b0, REG_LOCK, 32'h0);
    chk("lock_after_junk", 64'h4, q);
    wb(1'b0, REG_OPTION, 32'h0);
    chk("opt_after_junk", 64'h81, q);
    $display("t_masks done");
  endtask
  task automatic t_pages();
    flog.delete();
    cmd({16'h0002, OPC_WPL}, 32'h0000_03FC);
    u_prog.put(32'hA5A5_0001);
    u_prog.put(32'h5A5A_0002);
    wlog(2);
    chk("flush_cross", {FOP_PROGRAM, 8'h01, 32'hA5A5_0001}, flog[0]);
    chk("flush_count", {FOP_PROGRAM, 8'h02, 32'h5A5A_0002}, flog[1]);
    chk("lock_wpl", 64'h5, lock);
    pw({16'h0001, OPC_ERASE_WRITE_THEN_LOCK}, 32'h0000_6000, 32'h1234_5678);
    chk("lock_erase_write_then_lock", 64'hD, lock);
    pw({16'h0001, OPC_EWP}, 32'h0000_8000, 32'h8765_4321);
    chk("lock_ewp", 64'hD, lock);
    $display("t_pages done");
  endtask
  task automatic t_erase();
    cmd(OPC_CLB, 32'hFFFF_FFFF);
    flog.delete();
    u_prog.put({16'h0000, OPC_EA});
    wlog(1);
    chk("erase_all", FOP_ERASE_ALL, flog[0][41:40]);
    chk("opt_cleared", 64'h0, opt);
    cmd({16'h0002, OPC_MWR}, 32'h2000_0000);
    u_prog.put(32'hCAFE_0000);
    u_prog.put(32'hCAFE_0001);
    cmd(OPC_GVER, 32'h0000_00FF);
    chk("mem_first", {32'h2000_0000, 32'hCAFE_0000}, mlog[0]);
    chk("mem_next", {32'h2000_0004, 32'hCAFE_0001}, mlog[1]);
    $display("t_erase done");
  endtask
  task automatic t_secure();
    cmd(OPC_SLB, 32'h0000_0003);
    flog.delete();
    u_prog.put({16'h0000, OPC_SSEC});
    cmd(OPC_CLB, 32'h0000_0003);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("sec_status", 64'h1, q[STAT_SEC_BIT]);
    chk("lock_kept", 64'h3, lock);
    erase <= 1'b1;
    repeat (40) @(posedge clk_i);
    {tsel, ce} <= 2'h0;
    repeat (40) @(posedge clk_i);
    {ce, erase} <= 2'h2;
    repeat (10) @(posedge clk_i);
    erase <= 1'b1;
    repeat (10) @(posedge clk_i);
    erase <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk("sec_short", 64'h1, sec);
    erase <= 1'b1;
    repeat (40) @(posedge clk_i);
    erase <= 1'b0;
    wlog(1);
    chk("sec_cleared", 64'h0, {sec, lock});
    $display("t_secure done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_masks();
    t_pages();
    t_erase();
    t_secure();
    chk("poll_hang", 64'h0, hang);
    end_sim();
  end
endmodule // fpe_engine_bench
`default_nettype wire

// file: fpe_engine_monitor.sv
// Port-level checks for the flash programming command engine.
`timescale 1ns/1ps
`default_nettype none
module fpe_engine_monitor
  import fpe_pkg::*;
#(
  parameter int LOCK_W = 32,
  parameter int OPT_W = 8
) (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Flash macro and memory port.
  input wire logic flash_req_o,
  input wire fpe_fop_t flash_op_o,
  input wire logic flash_done_i,
  input wire logic mem_wr_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  // Protection state.
  input wire logic secured_o,
  input wire logic [LOCK_W-1:0] lock_bits_o,
  input wire logic [OPT_W-1:0] user_option_bits_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  wire logic ea_done = flash_done_i && flash_req_o && flash_op_o == FOP_ERASE_ALL;
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  a_unmapped_zero: assert property (rd_ack && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C})
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_sec_status: assert property (
    rd_ack && wb_adr_i == REG_STATUS |-> wb_dat_o[STAT_SEC_BIT] == $past(secured_o))
    else $error("status secure bit wrong");
  a_sec_clear: assert property ($fell(secured_o) |-> $past(ea_done))
    else $error("secure cleared without erase");
  a_erase_wipes: assert property (
    ea_done |-> ##[1:2] lock_bits_o == '0 && user_option_bits_o == '0)
    else $error("erase left lock or option bits");
  a_req_hold: assert property (flash_req_o && !flash_done_i |=> flash_req_o && $stable(flash_op_o))
    else $error("flash request dropped early");
  a_mem_hold: assert property (mem_wr_o && !mem_ack_i |=> mem_wr_o && $stable(mem_addr_o)
    && $stable(mem_wdata_o)) else $error("memory write dropped early");
endmodule // fpe_engine_monitor
bind fpe_engine fpe_engine_monitor #(.LOCK_W(LOCK_W), .OPT_W(OPT_W)) u_mon (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .flash_req_o, .flash_op_o,
  .flash_done_i, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .secured_o, .lock_bits_o,
  .user_option_bits_o);
`default_nettype wire

// file: fpe_page_buf.sv
// One-page load buffer with a write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module fpe_page_buf #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock and enable.
  input wire logic clk_i,
  input wire logic ce_i,
  // Write port.
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  // Read port.
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
        mem[waddr_i] <= wdata_i;
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // fpe_page_buf
`default_nettype wire

// file: fpe_pkg.sv
// Shared constants for the flash programming command engine.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package fpe_pkg;

  // Scan register layout.
  localparam int SCAN_W = 38;
  localparam int DATA_W = 32;
  localparam int SCAN_ADDR_LSB = 32;
  localparam int SCAN_ADDR_W = 5;
  localparam int SCAN_RW_BIT = 37;
  localparam logic [4:0] SCAN_ADDR_CTRL = 5'h04;
  localparam logic [4:0] SCAN_ADDR_DATA = 5'h05;
  localparam int CTRL_RXP_BIT = 0;
  localparam int CTRL_TXV_BIT = 1;

  // Command header layout and addressing.
  localparam int COUNT_LSB = 16;
  localparam int OPCODE_W = 16;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // Default opcodes and version word; the values are arbitrary.
  localparam logic [15:0] OPC_WP = 16'h0051;
  localparam logic [15:0] OPC_WPL = 16'h0052;
  localparam logic [15:0] OPC_EWP = 16'h0053;
  localparam logic [15:0] OPC_ERASE_WRITE_THEN_LOCK = 16'h0054;
  localparam logic [15:0] OPC_EA = 16'h0055;
  localparam logic [15:0] OPC_SLB = 16'h0056;
  localparam logic [15:0] OPC_CLB = 16'h0057;
  localparam logic [15:0] OPC_GLB = 16'h0058;
  localparam logic [15:0] OPC_SOPT = 16'h0059;
  localparam logic [15:0] OPC_COPT = 16'h005A;
  localparam logic [15:0] OPC_GOPT = 16'h005B;
  localparam logic [15:0] OPC_SSEC = 16'h005C;
  localparam logic [15:0] OPC_MWR = 16'h005D;
  localparam logic [15:0] OPC_GVER = 16'h005E;
  localparam logic [31:0] IF_VERSION = 32'h0000_0001;

  // Wishbone register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOCK = 8'h08;
  localparam logic [7:0] REG_OPTION = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SEC_BIT = 1;
  localparam int STAT_RXP_BIT = 2;
  localparam int STAT_TXV_BIT = 3;

  // Timing.
  localparam longint CLK_HZ = 20_000_000;
  localparam longint ERASE_HOLD_MS = 220;
  localparam longint ERASE_HOLD_CYCLES = ERASE_HOLD_MS * CLK_HZ / 1000 + 1;

  // Flash macro operations.
  typedef enum logic [1:0] {
    FOP_NONE = 2'h0,
    FOP_ERASE_PAGE = 2'h1,
    FOP_PROGRAM = 2'h2,
    FOP_ERASE_ALL = 2'h3
  } fpe_fop_t;

endpackage

// file: fpe_prog_model.sv
// Programmer model that drives the scan port one register access at a time.
`timescale 1ns/1ps
`default_nettype none
module fpe_prog_model (
  // Clock and scan pins.
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  // Set when a poll ran out of tries.
  output logic hang_o
);
  initial
  begin
    {tck_o, tms_o, tdi_o, hang_o} = 4'h6;
  end
  // Each access leaves from Run-Test/Idle, so the first one also leaves Test-Logic-Reset.
  task automatic scan(input logic [37:0] sr, output logic [31:0] rd);
    logic [43:0] ms;
    logic [43:0] di;
    ms = {3'h3, 37'h0, 4'h2};
    di = {2'h3, sr, 4'hF};
    for (int i = 0; i < 44; i++)
    begin
      tms_o <= ms[i];
      tdi_o <= di[i];
      tck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      if (i > 3 && i < 36) rd[i-4] = tdo_i;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task automatic poll(input int b, input logic v);
    logic [31:0] c;
    scan({1'b0, 5'h04, 32'h0}, c);
    for (int n = 0; n < 30; n++)
    begin
      scan({1'b0, 5'h04, 32'h0}, c);
      if (c[b] == v) return;
    end
    hang_o = 1'b1;
  endtask
  task automatic put(input logic [31:0] w);
    logic [31:0] c;
    poll(0, 1'b0);
    scan({1'b1, 5'h05, w}, c);
  endtask
  task automatic get(output logic [31:0] w);
    poll(1, 1'b1);
    scan({1'b0, 5'h05, 32'h0}, w);
    scan({1'b0, 5'h05, 32'h0}, w);
  endtask
endmodule // fpe_prog_model
`default_nettype wire

// file: fpe_sync.sv
// Two-flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module fpe_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Levels.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // fpe_sync
`default_nettype wire
